// >>> hw/ccd_core.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ccd_regs.svh"

// Operation
// - Watchdog kick zeroes counter and prescaler
// - Watchdog kick sets expiry and sleep flags
// - Call pushes program counter plus one
// - Call loads literal, page bits fill top
// - Call takes two cycles, flags untouched
// - Invert complements register, updates zero flag
// - Register clear writes zero, sets zero
// - Accumulator clear writes zero, sets zero
// - Decrement register, update zero, select destination
// - Decrement-skip stores result, flags untouched
// - Zero result discards next instruction as nop
// - Seven-bit register address, one-bit destination
module ccd_core #(
  parameter int STACK_DEPTH = 8,
  parameter int WDOG_W = 8,
  parameter int PRESC_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] busAddr,
  input wire logic [31:0] busWrData,
  input wire logic busWrStb,
  input wire logic busRdStb,
  output logic [31:0] busRdData,
  // Core state
  output logic zeroFlag,
  output logic sleepFlag,
  output logic watchdogExpiryFlag,
  output logic [12:0] pcOut
);

  localparam int SPW = $clog2(STACK_DEPTH);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  ccd_pkg::ccd_state_t state_q;
  logic [7:0] acc_q;
  logic [12:0] pc_q;
  logic [7:0] pageLatchHigh_q;
  logic zero_q;
  logic sleep_q;
  logic expiry_q;
  logic skipPending_q;
  logic [WDOG_W-1:0] watchdogCounter_q;
  logic [PRESC_W-1:0] presc_q;
  logic [31:0] rdData_q;

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  logic cmdWr;
  ccd_pkg::ccd_op_t cmdOp;
  logic cmdDest;
  logic [6:0] cmdReg;
  logic [10:0] cmdLit;
  logic accept;
  logic discard;
  logic exec;

  // Fields of the command word
  assign cmdWr = busWrStb && (busAddr == `CCD_OFF_CMD);
  assign cmdOp = ccd_pkg::ccd_op_t'(busWrData[`CCD_CMD_OP_MSB:`CCD_CMD_OP_LSB]);
  assign cmdDest = busWrData[`CCD_CMD_DEST_BIT];
  assign cmdReg = busWrData[`CCD_CMD_FREG_MSB:`CCD_CMD_FREG_LSB];
  assign cmdLit = busWrData[`CCD_CMD_LIT_MSB:`CCD_CMD_LIT_LSB];

  // Commands during the call tail are refused; a pending skip eats one
  assign accept = cmdWr && (state_q == ccd_pkg::CCD_ST_RUN);
  assign discard = accept && skipPending_q;
  assign exec = accept && !skipPending_q;

  // --------------------------------------------------------------------------
  // Operand fetch and arithmetic
  // --------------------------------------------------------------------------
  logic [7:0] fileVal;
  logic [7:0] fileBusVal;
  logic [7:0] result;
  logic resZero;
  logic opUsesDest;

  // Result of the register operations
  always_comb begin
    result = `CCD_BYTE_ZERO;
    opUsesDest = 1'b0;
    case (cmdOp)
      ccd_pkg::CCD_INVERT_OP: begin
        result = ~fileVal;
        opUsesDest = 1'b1;
      end
      ccd_pkg::CCD_REG_DECREMENT_OP: begin
        result = fileVal - `CCD_BYTE_ONE;
        opUsesDest = 1'b1;
      end
      ccd_pkg::CCD_DECREMENT_SKIP_ON_NULL_OP: begin
        result = fileVal - `CCD_BYTE_ONE;
        opUsesDest = 1'b1;
      end
      default: begin
        result = `CCD_BYTE_ZERO;
        opUsesDest = 1'b0;
      end
    endcase
  end

  // Zero test over the full byte
  assign resZero = (result == `CCD_BYTE_ZERO);

  // --------------------------------------------------------------------------
  // Data register file
  // --------------------------------------------------------------------------
  logic fileWe;
  logic fileOpWe;
  logic [6:0] fileWrAddr;
  logic [7:0] fileWrData;
  logic fileBusWe;

  // Operation writes back to the register or clears it
  assign fileOpWe = exec && ((opUsesDest && cmdDest) ||
    (cmdOp == ccd_pkg::CCD_REG_CLEAR_OP));
  assign fileBusWe = busWrStb && busAddr[`CCD_FILE_SEL_BIT];
  assign fileWe = fileOpWe || fileBusWe;
  assign fileWrAddr = fileOpWe ? cmdReg : busAddr[6:0];
  assign fileWrData = fileOpWe ? result : busWrData[7:0];

  ccd_data_file #(
    .AW(7),
    .DW(8)
  ) uFile (
    .clk(core_clk),
    .wrEn(fileWe),
    .wrAddr(fileWrAddr),
    .wrData(fileWrData),
    .rdAddrA(cmdReg),
    .rdDataA(fileVal),
    .rdAddrB(busAddr[6:0]),
    .rdDataB(fileBusVal)
  );

  // --------------------------------------------------------------------------
  // Return stack
  // --------------------------------------------------------------------------
  logic stackPush;
  logic [12:0] stackHead;
  logic [SPW-1:0] stackLevel;

  // Return address is the following instruction
  assign stackPush = exec && (cmdOp == ccd_pkg::CCD_CALL_OP);

  ccd_return_stack #(
    .DEPTH(STACK_DEPTH),
    .W(13)
  ) uStack (
    .clk(core_clk),
    .arst_n(arst_n),
    .push(stackPush),
    .pushData(pc_q + `CCD_PC_STEP),
    .head(stackHead),
    .level(stackLevel)
  );

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // Call holds a second cycle; everything else retires at once
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ccd_pkg::CCD_ST_RUN;
    end else begin
      case (state_q)
        ccd_pkg::CCD_ST_RUN: begin
          if (stackPush) begin
            state_q <= ccd_pkg::CCD_ST_CALL_TAIL;
          end
        end
        ccd_pkg::CCD_ST_CALL_TAIL: begin
          state_q <= ccd_pkg::CCD_ST_RUN;
        end
        default: begin
          state_q <= ccd_pkg::CCD_ST_RUN;
        end
      endcase
    end
  end

  // Skip request from a zero decrement-skip result
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      skipPending_q <= `CCD_RST_SKIP;
    end else if (exec && (cmdOp == ccd_pkg::CCD_DECREMENT_SKIP_ON_NULL_OP)) begin
      skipPending_q <= resZero;
    end else if (discard) begin
      skipPending_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Program counter and page latch
  // --------------------------------------------------------------------------
  // Program counter: call target, step, or software load
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_q <= `CCD_RST_PC;
    end else if (stackPush) begin
      pc_q <= {pageLatchHigh_q[`CCD_PAGE_MSB:`CCD_PAGE_LSB], cmdLit};
    end else if (accept) begin
      pc_q <= pc_q + `CCD_PC_STEP;
    end else if (busWrStb && (busAddr == `CCD_OFF_PC)) begin
      pc_q <= busWrData[12:0];
    end
  end

  // Page latch, software only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pageLatchHigh_q <= `CCD_RST_PAGE;
    end else if (busWrStb && (busAddr == `CCD_OFF_PAGE)) begin
      pageLatchHigh_q <= busWrData[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // Accumulator
  // --------------------------------------------------------------------------
  // Destination select zero lands the result here
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= `CCD_RST_ACC;
    end else if (exec && opUsesDest && !cmdDest) begin
      acc_q <= result;
    end else if (exec && (cmdOp == ccd_pkg::CCD_ACC_CLEAR_OP)) begin
      acc_q <= `CCD_BYTE_ZERO;
    end else if (busWrStb && (busAddr == `CCD_OFF_ACC)) begin
      acc_q <= busWrData[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------------
  logic statusWr;
  logic wdogKick;
  logic wdogWrap;

  assign statusWr = busWrStb && (busAddr == `CCD_OFF_STATUS);
  assign wdogKick = exec && (cmdOp == ccd_pkg::CCD_WATCHDOG_KICK_OP);

  // Zero flag; call, skip and kick leave it alone
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_q <= `CCD_RST_ZERO;
    end else if (exec) begin
      case (cmdOp)
        ccd_pkg::CCD_INVERT_OP: zero_q <= resZero;
        ccd_pkg::CCD_REG_DECREMENT_OP: zero_q <= resZero;
        ccd_pkg::CCD_REG_CLEAR_OP: zero_q <= 1'b1;
        ccd_pkg::CCD_ACC_CLEAR_OP: zero_q <= 1'b1;
        default: zero_q <= zero_q;
      endcase
    end else if (statusWr) begin
      zero_q <= busWrData[`CCD_ST_ZERO_BIT];
    end
  end

  // Sleep flag set by the kick
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_q <= `CCD_RST_SLEEP;
    end else if (wdogKick) begin
      sleep_q <= 1'b1;
    end else if (statusWr) begin
      sleep_q <= busWrData[`CCD_ST_SLEEP_BIT];
    end
  end

  // Expiry flag: kick sets it, a counter wrap drops it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      expiry_q <= `CCD_RST_EXPIRY;
    end else if (wdogKick) begin
      expiry_q <= 1'b1;
    end else if (wdogWrap) begin
      expiry_q <= 1'b0;
    end else if (statusWr) begin
      expiry_q <= busWrData[`CCD_ST_EXPIRY_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Watchdog counter and prescaler
  // --------------------------------------------------------------------------
  logic prescTick;

  assign prescTick = (presc_q == {PRESC_W{1'b1}});
  assign wdogWrap = prescTick && (watchdogCounter_q == {WDOG_W{1'b1}});

  // Free-running count, cleared by the kick
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_q <= '0;
      watchdogCounter_q <= '0;
    end else if (wdogKick) begin
      presc_q <= '0;
      watchdogCounter_q <= '0;
    end else begin
      presc_q <= presc_q + PRESC_W'(1);
      if (prescTick) begin
        watchdogCounter_q <= watchdogCounter_q + WDOG_W'(1);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------------
  logic [31:0] rdMux;

  // Read selection; unmapped addresses read zero
  always_comb begin
    rdMux = `CCD_RD_IDLE;
    if (busAddr[`CCD_FILE_SEL_BIT]) begin
      rdMux[7:0] = fileBusVal;
    end else begin
      case (busAddr)
        `CCD_OFF_STATUS: begin
          rdMux[`CCD_ST_ZERO_BIT] = zero_q;
          rdMux[`CCD_ST_SLEEP_BIT] = sleep_q;
          rdMux[`CCD_ST_EXPIRY_BIT] = expiry_q;
          rdMux[`CCD_ST_BUSY_BIT] = (state_q == ccd_pkg::CCD_ST_CALL_TAIL);
          rdMux[`CCD_ST_SKIP_BIT] = skipPending_q;
        end
        `CCD_OFF_ACC: rdMux[7:0] = acc_q;
        `CCD_OFF_PC: rdMux[12:0] = pc_q;
        `CCD_OFF_PAGE: rdMux[7:0] = pageLatchHigh_q;
        `CCD_OFF_STACK: begin
          rdMux[12:0] = stackHead;
          rdMux[`CCD_STACK_LEVEL_LSB +: SPW] = stackLevel;
        end
        `CCD_OFF_WDOG: begin
          rdMux[WDOG_W-1:0] = watchdogCounter_q;
          rdMux[`CCD_WDOG_PRESC_LSB +: PRESC_W] = presc_q;
        end
        default: rdMux = `CCD_RD_IDLE;
      endcase
    end
  end

  // Read data valid in the cycle after the strobe only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= `CCD_RD_IDLE;
    end else begin
      rdData_q <= busRdStb ? rdMux : `CCD_RD_IDLE;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign busRdData = rdData_q;
  assign zeroFlag = zero_q;
  assign sleepFlag = sleep_q;
  assign watchdogExpiryFlag = expiry_q;
  assign pcOut = pc_q;

endmodule // ccd_core

// >>> hw/ccd_regs.svh
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CCD_OFF_CMD 8'h00
`define CCD_OFF_STATUS 8'h04
`define CCD_OFF_ACC 8'h08
`define CCD_OFF_PC 8'h0C
`define CCD_OFF_PAGE 8'h10
`define CCD_OFF_STACK 8'h14
`define CCD_OFF_WDOG 8'h18
// Address bit that selects the data register file window
`define CCD_FILE_SEL_BIT 7

// ----------------------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------------------
`define CCD_CMD_OP_LSB 0
`define CCD_CMD_OP_MSB 2
`define CCD_CMD_DEST_BIT 3
`define CCD_CMD_FREG_LSB 4
`define CCD_CMD_FREG_MSB 10
`define CCD_CMD_LIT_LSB 16
`define CCD_CMD_LIT_MSB 26

// ----------------------------------------------------------------------------
// Status, page latch, stack and watchdog read fields
// ----------------------------------------------------------------------------
`define CCD_ST_ZERO_BIT 0
`define CCD_ST_SLEEP_BIT 1
`define CCD_ST_EXPIRY_BIT 2
`define CCD_ST_BUSY_BIT 3
`define CCD_ST_SKIP_BIT 4
`define CCD_PAGE_LSB 3
`define CCD_PAGE_MSB 4
`define CCD_STACK_LEVEL_LSB 16
`define CCD_WDOG_PRESC_LSB 8

// ----------------------------------------------------------------------------
// Reset and constant values
// ----------------------------------------------------------------------------
`define CCD_RST_ACC 8'h00
`define CCD_RST_PC 13'h0000
`define CCD_RST_PAGE 8'h00
`define CCD_RST_ZERO 1'b0
`define CCD_RST_SLEEP 1'b1
`define CCD_RST_EXPIRY 1'b1
`define CCD_RST_SKIP 1'b0
`define CCD_BYTE_ZERO 8'h00
`define CCD_BYTE_ONE 8'h01
`define CCD_PC_STEP 13'h0001
`define CCD_RD_IDLE 32'h0000_0000

`endif

// >>> hw/ccd_pkg.sv
package ccd_pkg;

  // Operation codes carried in the command word
  typedef enum logic [2:0] {
    CCD_NOP_OP = 3'h0,
    CCD_WATCHDOG_KICK_OP = 3'h1,
    CCD_CALL_OP = 3'h2,
    CCD_INVERT_OP = 3'h3,
    CCD_REG_CLEAR_OP = 3'h4,
    CCD_ACC_CLEAR_OP = 3'h5,
    CCD_REG_DECREMENT_OP = 3'h6,
    CCD_DECREMENT_SKIP_ON_NULL_OP = 3'h7
  } ccd_op_t;

  // Sequencer states
  typedef enum logic {
    CCD_ST_RUN,
    CCD_ST_CALL_TAIL
  } ccd_state_t;

endpackage

// >>> hw/ccd_data_file.sv
`timescale 1ns/1ps

// Data register file: one write port, two combinational read ports
module ccd_data_file #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  // Read ports
  input wire logic [AW-1:0] rdAddrA,
  output logic [DW-1:0] rdDataA,
  input wire logic [AW-1:0] rdAddrB,
  output logic [DW-1:0] rdDataB
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Storage write
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Read paths
  assign rdDataA = mem[rdAddrA];
  assign rdDataB = mem[rdAddrB];

endmodule // ccd_data_file

// >>> hw/ccd_return_stack.sv
`timescale 1ns/1ps

// Circular return stack; pushing past the depth overwrites the oldest entry
module ccd_return_stack #(
  parameter int DEPTH = 8,
  parameter int W = 13,
  parameter int PW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Push side
  input wire logic push,
  input wire logic [W-1:0] pushData,
  // Observation
  output logic [W-1:0] head,
  output logic [PW-1:0] level
);

  logic [W-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] ptr_q;

  // Entry write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[ptr_q] <= pushData;
    end
  end

  // Pointer advance, wraps at the depth
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= '0;
    end else if (push) begin
      ptr_q <= (ptr_q == PW'(DEPTH - 1)) ? '0 : ptr_q + PW'(1);
    end
  end

  // Head is the most recent entry
  assign head = mem[(ptr_q == '0) ? PW'(DEPTH - 1) : ptr_q - PW'(1)];
  assign level = ptr_q;

endmodule // ccd_return_stack

// >>> dv/ccd_core_chk.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Port-level checker for the operation core
// ----------------------------------------------------------------------------
module ccd_core_chk #(
  parameter int STACK_DEPTH = 8,
  parameter int WDOG_W = 8,
  parameter int PRESC_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] busAddr,
  input wire logic [31:0] busWrData,
  input wire logic busWrStb,
  input wire logic busRdStb,
  input wire logic [31:0] busRdData,
  // Core state
  input wire logic zeroFlag,
  input wire logic sleepFlag,
  input wire logic watchdogExpiryFlag,
  input wire logic [12:0] pcOut
);
  logic cmdWr;
  logic sure;
  logic [2:0] op;
  logic busyQ;
  logic ambigQ;
  logic [1:0] pageQ;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Command seen on the bus; sure when neither busy nor after a skip op
  assign cmdWr = busWrStb && (busAddr == 8'h00);
  assign op = busWrData[2:0];
  assign sure = cmdWr && !busyQ && !ambigQ;

  // Busy tail, skip ambiguity and page bits tracking
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busyQ <= 1'b0;
      ambigQ <= 1'b0;
      pageQ <= 2'h0;
    end else begin
      busyQ <= sure && (op == 3'h2);
      if (cmdWr && !busyQ) begin
        ambigQ <= (op == 3'h7) || (ambigQ && (op == 3'h2));
      end
      if (busWrStb && (busAddr == 8'h10)) begin
        pageQ <= busWrData[4:3];
      end
    end
  end

  a_kick_flags: assert property (sure && op == 3'h1 |=> sleepFlag && watchdogExpiryFlag)
    else $error("kick did not set sleep and expiry flags");
  a_kick_zero: assert property (sure && op == 3'h1 |=> $stable(zeroFlag))
    else $error("kick altered zero flag");
  a_call_target: assert property (sure && op == 3'h2
    |=> pcOut == {$past(pageQ), $past(busWrData[26:16])})
    else $error("call target wrong");
  a_call_ignore: assert property (sure && op == 3'h2 ##1 cmdWr |=> $stable(pcOut))
    else $error("command accepted during call tail");
  a_call_flags: assert property (sure && op == 3'h2
    |=> $stable(zeroFlag) && $stable(sleepFlag))
    else $error("call altered flags");
  a_clear_zero: assert property (sure && (op == 3'h4 || op == 3'h5) |=> zeroFlag)
    else $error("clear did not set zero flag");
  a_skip_zero: assert property (sure && op == 3'h7 |=> $stable(zeroFlag))
    else $error("decrement skip altered zero flag");
  a_pc_step: assert property (sure && op != 3'h2
    |=> pcOut == $past(pcOut) + 13'h0001)
    else $error("program counter did not step by one");
  a_rd_idle: assert property (!busRdStb |=> busRdData == 32'h0000_0000)
    else $error("read data not idle without a read strobe");
endmodule // ccd_core_chk

bind ccd_core ccd_core_chk #(
  .STACK_DEPTH(STACK_DEPTH),
  .WDOG_W(WDOG_W),
  .PRESC_W(PRESC_W)
) u_chk (
  .core_clk(core_clk),
  .arst_n(arst_n),
  .busAddr(busAddr),
  .busWrData(busWrData),
  .busWrStb(busWrStb),
  .busRdStb(busRdStb),
  .busRdData(busRdData),
  .zeroFlag(zeroFlag),
  .sleepFlag(sleepFlag),
  .watchdogExpiryFlag(watchdogExpiryFlag),
  .pcOut(pcOut)
);

// >>> dv/tb.sv
`timescale 1ns/1ps
`include "ccd_regs.svh"

// ----------------------------------------------------------------------------
// Register-driven bench for the operation core
// ----------------------------------------------------------------------------
module tb;
  logic core_clk;
  logic arst_n;
  logic [7:0] busAddr;
  logic [31:0] busWrData;
  logic busWrStb;
  logic busRdStb;
  logic [31:0] busRdData;
  logic zeroFlag;
  logic sleepFlag;
  logic watchdogExpiryFlag;
  logic [12:0] pcOut;
  int nMismatch;
  int checkCount;
  logic [12:0] ePc;
  logic [7:0] pgTab [3] = '{8'h18, 8'hE7, 8'h08};
  logic [10:0] litTab [3] = '{11'h7FF, 11'h555, 11'h000};
  ccd_pkg::ccd_op_t opTab [8] = '{ccd_pkg::CCD_INVERT_OP, ccd_pkg::CCD_INVERT_OP,
    ccd_pkg::CCD_REG_CLEAR_OP, ccd_pkg::CCD_ACC_CLEAR_OP, ccd_pkg::CCD_REG_DECREMENT_OP,
    ccd_pkg::CCD_REG_DECREMENT_OP, ccd_pkg::CCD_DECREMENT_SKIP_ON_NULL_OP,
    ccd_pkg::CCD_DECREMENT_SKIP_ON_NULL_OP};
  logic dTab [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [6:0] fTab [8] = '{7'h05, 7'h06, 7'h7F, 7'h09, 7'h0A, 7'h0B, 7'h14, 7'h15};
  logic [7:0] preTab [8] = '{8'h0F, 8'hFF, 8'h33, 8'h5A, 8'h01, 8'h00, 8'h02, 8'h80};
  logic [7:0] resTab [8] = '{8'hF0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h01, 8'h7F};
  logic pzTab [8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic ezTab [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  ccd_core u_dut (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .busAddr(busAddr),
    .busWrData(busWrData),
    .busWrStb(busWrStb),
    .busRdStb(busRdStb),
    .busRdData(busRdData),
    .zeroFlag(zeroFlag),
    .sleepFlag(sleepFlag),
    .watchdogExpiryFlag(watchdogExpiryFlag),
    .pcOut(pcOut)
  );

  // Clock at 40 MHz
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Command word builder
  function automatic logic [31:0] cw(ccd_pkg::ccd_op_t op, logic d, logic [6:0] f,
      logic [10:0] lit);
    return {5'h00, lit, 5'h00, f, d, op};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      nMismatch++;
    end
  endtask

  // One-cycle write, then a settle step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    busWrStb <= 1'b1;
    busAddr <= a;
    busWrData <= d;
    @(posedge core_clk);
    busWrStb <= 1'b0;
    #1;
  endtask

  // Two command writes back to back
  task automatic wr2(input logic [31:0] d1, input logic [31:0] d2);
    @(posedge core_clk);
    busWrStb <= 1'b1;
    busAddr <= `CCD_OFF_CMD;
    busWrData <= d1;
    @(posedge core_clk);
    busWrData <= d2;
    @(posedge core_clk);
    busWrStb <= 1'b0;
    #1;
  endtask

  // Read and compare under a mask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm,
      input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge core_clk);
    busRdStb <= 1'b1;
    busAddr <= a;
    @(posedge core_clk);
    busRdStb <= 1'b0;
    #1;
    chk(nm, exp & m, busRdData & m);
  endtask

  task automatic cmd(input ccd_pkg::ccd_op_t op, input logic d, input logic [6:0] f);
    wr(`CCD_OFF_CMD, cw(op, d, f, 11'h100));
    ePc = ePc + 13'h0001;
  endtask

  task automatic printVerdict();
    if (nMismatch == 0 && checkCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #500000;
    nMismatch++;
    printVerdict();
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    busAddr = 8'h00;
    busWrData = 32'h0000_0000;
    busWrStb = 1'b0;
    busRdStb = 1'b0;
    nMismatch = 0;
    checkCount = 0;
    ePc = 13'h0000;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(`CCD_OFF_STATUS, 32'h0000_0006, "status reset");
    // Kick after the watchdog has run a while
    repeat (600) @(posedge core_clk);
    wr(`CCD_OFF_STATUS, 32'h0000_0001);
    cmd(ccd_pkg::CCD_WATCHDOG_KICK_OP, 1'b0, 7'h00);
    rd(`CCD_OFF_STATUS, 32'h0000_0007, "status kick");
    rd(`CCD_OFF_WDOG, 32'h0000_0000, "wdog kick", 32'hFFFF_F8FF);
    // Calls with an ignored command in the busy cycle
    wr({1'b1, 7'h05}, 32'h0000_000F);
    for (int i = 0; i < 3; i++) begin
      wr(`CCD_OFF_PAGE, {24'h0, pgTab[i]});
      wr(`CCD_OFF_PC, 32'h0000_0123);
      wr2(cw(ccd_pkg::CCD_CALL_OP, 1'b0, 7'h00, litTab[i]),
        cw(ccd_pkg::CCD_INVERT_OP, 1'b1, 7'h05, 11'h000));
      ePc = {pgTab[i][4:3], litTab[i]};
      chk("pc call", {19'h0, ePc}, {19'h0, pcOut});
      rd(`CCD_OFF_STACK, 32'h0000_0124, "stack head", 32'h0000_1FFF);
    end
    rd({1'b1, 7'h05}, 32'h0000_000F, "ignored command");
    rd(`CCD_OFF_STATUS, 32'h0000_0007, "status call", 32'h0000_001F);
    // Table of register operations
    for (int i = 0; i < 8; i++) begin
      wr({1'b1, fTab[i]}, {24'h0, preTab[i]});
      wr(`CCD_OFF_ACC, 32'h0000_00A5);
      wr(`CCD_OFF_STATUS, {31'h3, pzTab[i]});
      cmd(opTab[i], dTab[i], fTab[i]);
      rd(`CCD_OFF_ACC, {24'h0, dTab[i] ? 8'hA5 : resTab[i]}, "acc op");
      rd({1'b1, fTab[i]}, {24'h0, dTab[i] ? resTab[i] : preTab[i]}, "reg op");
      rd(`CCD_OFF_STATUS, {31'h0, ezTab[i]}, "zero op", 32'h0000_0011);
    end
    // Zero result discards the very next command
    wr({1'b1, 7'h1E}, 32'h0000_0001);
    wr(`CCD_OFF_ACC, 32'h0000_0077);
    wr(`CCD_OFF_STATUS, 32'h0000_0006);
    wr2(cw(ccd_pkg::CCD_DECREMENT_SKIP_ON_NULL_OP, 1'b1, 7'h1E, 11'h000),
      cw(ccd_pkg::CCD_ACC_CLEAR_OP, 1'b0, 7'h00, 11'h000));
    ePc = ePc + 13'h0002;
    rd(`CCD_OFF_ACC, 32'h0000_0077, "acc discarded");
    rd(`CCD_OFF_STATUS, 32'h0000_0006, "status discarded", 32'h0000_001F);
    rd({1'b1, 7'h1E}, 32'h0000_0000, "reg skip");
    // Accumulator destination, then a discarded call
    wr({1'b1, 7'h1F}, 32'h0000_0001);
    cmd(ccd_pkg::CCD_DECREMENT_SKIP_ON_NULL_OP, 1'b0, 7'h1F);
    rd(`CCD_OFF_STATUS, 32'h0000_0016, "skip pending", 32'h0000_001F);
    cmd(ccd_pkg::CCD_CALL_OP, 1'b0, 7'h00);
    chk("pc discarded call", {19'h0, ePc}, {19'h0, pcOut});
    rd(`CCD_OFF_ACC, 32'h0000_0000, "acc skip");
    rd({1'b1, 7'h1F}, 32'h0000_0001, "reg kept");
    // No-operation only steps the program counter
    cmd(ccd_pkg::CCD_NOP_OP, 1'b0, 7'h1F);
    chk("pc nop", {19'h0, ePc}, {19'h0, pcOut});
    rd(`CCD_OFF_ACC, 32'h0000_0000, "acc nop");
    // Command and unmapped addresses read zero
    rd(`CCD_OFF_CMD, 32'h0000_0000, "cmd read");
    rd(8'h1C, 32'h0000_0000, "unmapped read");
    printVerdict();
  end
endmodule // tb
